/* File: logic/psrow_bank.sv */
// psrow_bank: read-only production signature bank on an avalon-mm slave.
// assumes a master that holds its request until waitrequest is low.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - five lot bytes at consecutive offsets
// - wafer byte, top three bits zero
// - die x and y, two bytes each
// - holds 48 mhz oscillator trim byte
// - twelve-bit temperature reference, low byte first
module psrow_bank
  import psrow_pkg::*;
#(
  parameter logic [8*PSROW_DEPTH-1:0] FACTORY_IMAGE = '0
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  output logic o_write_seen
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    psrow_state_t state;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
    logic write_seen;
  } psrow_regs_t;

  psrow_regs_t state_reg;
  psrow_regs_t state_next;
  psrow_req_t req;
  logic mapped;
  logic [7:0] rom_byte;
  logic aligned;

  assign req.address = i_address;
  assign req.read = i_read;
  assign req.write = i_write;
  assign req.writedata = i_writedata;
  assign req.byteenable = i_byteenable;
  assign aligned = (req.address[1:0] == 2'b00);

  ////////////////////////////////////////////////////////////////////////
  // lot, wafer, die and trim bytes
  psrow_rom #(
    .FACTORY_IMAGE(FACTORY_IMAGE)
  ) u_rom (
    .i_index(req.address[7:2]),
    .o_mapped(mapped),
    .o_byte(rom_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // one wait cycle, then answer; read data registered so outputs are flops
  always_comb begin
    state_next = state_reg;
    state_next.waitrequest = 1'b1;
    unique case (state_reg.state)
      PSROW_ST_IDLE: begin
        if (req.read || req.write) begin
          state_next.state = PSROW_ST_DONE;
          state_next.waitrequest = 1'b0;
          state_next.response = PSROW_RESP_OKAY;
          state_next.readdata = PSROW_READ_ZERO;
          if (!(mapped && aligned)) begin
            state_next.response = PSROW_RESP_SLVERR;
          end else if (req.read) begin
            // byte 0 least significant, own word each
            state_next.readdata = {24'h00_0000, rom_byte};
          end
          if (req.write) begin
            state_next.write_seen = 1'b1;
          end
        end
      end
      PSROW_ST_DONE: begin
        state_next.state = PSROW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg.state <= PSROW_ST_IDLE;
      state_reg.readdata <= PSROW_READ_ZERO;
      state_reg.waitrequest <= 1'b1;
      state_reg.response <= PSROW_RESP_OKAY;
      state_reg.write_seen <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_readdata = state_reg.readdata;
  assign o_waitrequest = state_reg.waitrequest;
  assign o_response = state_reg.response;
  assign o_write_seen = state_reg.write_seen;

endmodule : psrow_bank
`default_nettype wire

/* File: logic/psrow_pkg.sv */
// psrow_pkg: offsets, field layouts and reset values of the production
// signature row bank.
// assumes a byte-indexed map, each byte held in one aligned 32-bit word.
package psrow_pkg;

  localparam int unsigned PSROW_IDX_W = 6;
  localparam int unsigned PSROW_DEPTH = 64;

  // register indices as printed; byte address is four times the index
  localparam logic [5:0] PSROW_LOT_ID_BYTE1 = 6'h09;
  localparam logic [5:0] PSROW_LOT_ID_BYTE2 = 6'h0a;
  localparam logic [5:0] PSROW_LOT_ID_BYTE3 = 6'h0b;
  localparam logic [5:0] PSROW_LOT_ID_BYTE4 = 6'h0c;
  localparam logic [5:0] PSROW_LOT_ID_BYTE5 = 6'h0d;
  localparam logic [5:0] PSROW_WAFER_ID = 6'h10;
  localparam logic [5:0] PSROW_DIE_X_LOW = 6'h12;
  localparam logic [5:0] PSROW_DIE_X_HIGH = 6'h13;
  localparam logic [5:0] PSROW_DIE_Y_LOW = 6'h14;
  localparam logic [5:0] PSROW_DIE_Y_HIGH = 6'h15;
  localparam logic [5:0] PSROW_USB_PAD_TRIM_LOW = 6'h1a;
  localparam logic [5:0] PSROW_USB_PAD_TRIM_HIGH = 6'h1b;
  localparam logic [5:0] PSROW_USB_OSC_TRIM = 6'h1c;
  localparam logic [5:0] PSROW_ADC_A_TRIM_LOW = 6'h20;
  localparam logic [5:0] PSROW_ADC_A_TRIM_HIGH = 6'h21;
  localparam logic [5:0] PSROW_ADC_B_TRIM_LOW = 6'h24;
  localparam logic [5:0] PSROW_ADC_B_TRIM_HIGH = 6'h25;
  localparam logic [5:0] PSROW_TEMP_REF_LOW = 6'h2e;
  localparam logic [5:0] PSROW_TEMP_REF_HIGH = 6'h2f;

  // field layouts
  localparam logic [7:0] PSROW_WAFER_MASK = 8'h1f;
  localparam logic [7:0] PSROW_TEMP_HIGH_MASK = 8'h0f;
  localparam logic [31:0] PSROW_READ_ZERO = 32'h0000_0000;
  localparam logic [7:0] PSROW_BYTE_ZERO = 8'h00;

  // bus side carrier
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } psrow_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
  } psrow_rsp_t;

  localparam logic [1:0] PSROW_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSROW_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PSROW_ST_IDLE = 2'b01,
    PSROW_ST_DONE = 2'b10
  } psrow_state_t;

endpackage : psrow_pkg

/* File: logic/psrow_rom.sv */
// psrow_rom: factory byte store, one masked byte per index.
// assumes factory values arrive as parameters; content is fixed.
`timescale 1ns/1ps
`default_nettype none
module psrow_rom
  import psrow_pkg::*;
#(
  parameter logic [8*PSROW_DEPTH-1:0] FACTORY_IMAGE = '0
) (
  input wire logic [PSROW_IDX_W-1:0] i_index,
  output logic o_mapped,
  output logic [7:0] o_byte
);

  logic [7:0] rom [PSROW_DEPTH];
  logic [7:0] mask;

  always_comb begin
    for (int k = 0; k < PSROW_DEPTH; k++) begin
      rom[k] = FACTORY_IMAGE[8*k +: 8];
    end
  end

  always_comb begin
    o_mapped = 1'b1;
    mask = 8'hff;
    unique case (i_index)
      PSROW_LOT_ID_BYTE1, PSROW_LOT_ID_BYTE2, PSROW_LOT_ID_BYTE3,
      PSROW_LOT_ID_BYTE4, PSROW_LOT_ID_BYTE5: mask = 8'hff;
      PSROW_WAFER_ID: mask = PSROW_WAFER_MASK;
      PSROW_DIE_X_LOW, PSROW_DIE_X_HIGH,
      PSROW_DIE_Y_LOW, PSROW_DIE_Y_HIGH: mask = 8'hff;
      PSROW_USB_PAD_TRIM_LOW, PSROW_USB_PAD_TRIM_HIGH,
      PSROW_USB_OSC_TRIM: mask = 8'hff;
      PSROW_ADC_A_TRIM_LOW, PSROW_ADC_A_TRIM_HIGH,
      PSROW_ADC_B_TRIM_LOW, PSROW_ADC_B_TRIM_HIGH: mask = 8'hff;
      PSROW_TEMP_REF_LOW: mask = 8'hff;
      PSROW_TEMP_REF_HIGH: mask = PSROW_TEMP_HIGH_MASK;
      default: begin
        o_mapped = 1'b0;
        mask = PSROW_BYTE_ZERO;
      end
    endcase
    o_byte = rom[i_index] & mask;
  end

endmodule : psrow_rom
`default_nettype wire

/* File: sim/psrow_bank_asserts.sv */
// checker: bus timing and content checks at the bank ports.
// assumes it is bound to every psrow_bank.
`timescale 1ns/1ps
`default_nettype none
module psrow_bank_asserts
  import psrow_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [1:0] o_response,
  input wire logic o_write_seen
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire rq = i_read | i_write;
  wire an = !o_waitrequest;
  sequence s_beat; an ##1 !an; endsequence
  property p_ans; rq && !an |=> an; endproperty
  property p_one; an |-> s_beat; endproperty
  property p_idle; !rq && !an |=> !an; endproperty
  property p_up; an |-> o_readdata[31:8] == 24'h00_0000; endproperty
  property p_bad; an && i_address[1:0] != 2'h0 |->
    o_response == PSROW_RESP_SLVERR && o_readdata == PSROW_READ_ZERO;
  endproperty
  property p_waf; an && i_read && i_address == 8'h40 |->
    o_readdata[7:5] == 3'h0; endproperty
  property p_seen; an && i_write |=> o_write_seen; endproperty
  property p_keep; o_write_seen |=> o_write_seen; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("long answer");
  a_idle: assert property (p_idle) else $error("answer unasked");
  a_up: assert property (p_up) else $error("upper bits set");
  a_bad: assert property (p_bad) else $error("unaligned ok");
  a_waf: assert property (p_waf) else $error("wafer top bits");
  a_seen: assert property (p_seen) else $error("write unseen");
  a_keep: assert property (p_keep) else $error("seen dropped");
endmodule : psrow_bank_asserts
bind psrow_bank psrow_bank_asserts u_chk (.i_clock(i_clock),
  .i_reset(i_reset), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_response(o_response),
  .o_write_seen(o_write_seen));
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: reads, writes and resets the bank over avalon-mm.
// assumes a bank built with the image below.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import psrow_pkg::*;
;
  function automatic logic [511:0] mk();
    for (int k = 0; k < 64; k++) mk[8*k+:8] = 8'(k) ^ 8'hc3;
  endfunction : mk
  function automatic logic [7:0] ex(input logic [5:0] k);
    ex = {2'b00, k} ^ 8'hc3;
    if (k == PSROW_WAFER_ID) ex &= PSROW_WAFER_MASK;
    if (k == PSROW_TEMP_REF_HIGH) ex &= PSROW_TEMP_HIGH_MASK;
  endfunction : ex
  localparam logic [511:0] IMG = mk();
  logic clk = 0, rs = 1, rd = 0, wr = 0, ow, ows;
  logic [7:0] ad = 8'h00;
  logic [31:0] d, od;
  logic [1:0] r, ors;
  int miscompares = 0, num_checks = 0;
  logic [7:0] ba [3] = '{8'h20, 8'h49, 8'hfc};
  logic [5:0] mp [19] = '{6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10,
    6'h12, 6'h13, 6'h14, 6'h15, 6'h1a, 6'h1b, 6'h1c, 6'h20, 6'h21,
    6'h24, 6'h25, 6'h2e, 6'h2f};
  psrow_bank #(.FACTORY_IMAGE(IMG)) DUT (.i_clock(clk), .i_reset(rs),
    .i_address(ad), .i_read(rd), .i_write(wr),
    .i_writedata(32'hffff_ffff), .i_byteenable(4'hf),
    .o_readdata(od), .o_waitrequest(ow), .o_response(ors),
    .o_write_seen(ows));
  initial forever #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // request held until waitrequest is seen low
  task acc(input logic w, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    // request stands until the edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (ow !== 1'b0 && n < 20);
    d = od;
    r = ors;
    if (n == 20) miscompares++;
    rd <= 0;
    wr <= 0;
  endtask : acc
  task t_map();
    logic [7:0] e;
    foreach (mp[i]) begin
      e = ex(mp[i]);
      acc(0, {mp[i], 2'b00});
      // every mapped byte read back for software to copy
      chk("rd", {24'h0, e}, d);
      chk("rsp", 32'h0, {30'h0, r});
    end
  endtask : t_map
  task t_bad();
    foreach (ba[i]) begin
      acc(0, ba[i]);
      chk("bad rd", 32'h0, d);
      chk("bad rsp", {30'h0, PSROW_RESP_SLVERR}, {30'h0, r});
    end
  endtask : t_bad
  task t_ro();
    foreach (mp[i]) acc(1, {mp[i], 2'b00});
    chk("seen", 32'h1, {31'h0, ows});
    t_map();
  endtask : t_ro
  task t_rst();
    rs <= 1;
    repeat (2) @(posedge clk);
    rs <= 0;
    @(negedge clk);
    chk("seen rst", 32'h0, {31'h0, ows});
    chk("wait rst", 32'h1, {31'h0, ow});
  endtask : t_rst
  initial begin
    repeat (8) @(posedge clk);
    rs <= 0;
    t_map();
    t_bad();
    t_ro();
    t_rst();
    t_map();
    conclude();
  end
  initial begin
    #20000;
    miscompares++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
